/* File: dv/ch3drv_output3_ctrl_sva.sv */
/*
 * assertion checker for the channel three driver control bank.
 * assumes it is bound onto ch3drv_output3_ctrl and sees only its ports.
 */
`timescale 1ns/10ps
module ch3drv_output3_ctrl_sva #(
    parameter int DIV_W   = 10,
    parameter int PHASE_W = 11
) (
    input wire logic               clk,
    input wire logic               reset,
    input wire logic [7:0]         reg_addr,
    input wire logic [7:0]         reg_wdata,
    input wire logic               reg_write,
    input wire logic               reg_read,
    input wire logic [7:0]         reg_rdata,
    input wire logic               reg_rvalid,
    input wire logic               output_sync,
    input wire logic [DIV_W-1:0]   ch3_divide_value,
    input wire logic [PHASE_W-1:0] ch3_phase_offset,
    input wire logic               clock_output_ch3_pos_oe,
    input wire logic               ch3_diff_active,
    input wire logic [2:0]         ch3_lvds_current,
    input wire logic               ch3_hstl_select,
    input wire logic               ch3_hstl_boost,
    input wire logic               ch3_half_cycle_shift,
    input wire logic               ch3_edge
);
    // single domain, async reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // read answered exactly one cycle later
    a_read_rvalid: assert property (reg_read |=> reg_rvalid)
        else $error("read not answered");
    // reserved bit of first register reads zero
    a_rsvd_zero: assert property (reg_read && reg_addr == 8'h2b |=> !reg_rdata[0])
        else $error("reserved bit read as one");
    // unmapped reads give zero
    a_unmapped_zero: assert property (reg_read && !(reg_addr inside {8'h2b, 8'h2c}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    // boost is a flavour of hstl, never lvds
    a_boost_hstl: assert property (ch3_hstl_boost |-> ch3_hstl_select && ch3_lvds_current == 3'h0)
        else $error("boost without hstl");
    // lvds strength codes one to four only
    a_lvds_range: assert property (ch3_lvds_current != 3'h0 |-> ch3_lvds_current <= 3'h4 && !ch3_hstl_select)
        else $error("lvds strength out of range");
    // odd half period goes to the fine stage
    a_half_shift: assert property (ch3_half_cycle_shift == ch3_phase_offset[0])
        else $error("half shift mismatch");
    // power-down idles the positive leg and the differential driver three cycles on
    a_pd_idle: assert property (reg_write && reg_addr == 8'h2b && reg_wdata[7] ##1 !reg_write [*3] |->
        !clock_output_ch3_pos_oe && !ch3_diff_active)
        else $error("power-down did not idle output");
    // edge is a single-cycle pulse except at divide by one
    a_edge_pulse: assert property (ch3_edge && ch3_divide_value != '0 |=> !ch3_edge)
        else $error("edge pulse too long");
    // divide by two repeats every second cycle
    a_div_two: assert property (
        ch3_edge && ch3_divide_value == DIV_W'(1) && !output_sync && !reg_write && !$past(reg_write)
        ##1 ch3_divide_value == DIV_W'(1) && !output_sync && !reg_write |=> ch3_edge)
        else $error("divide by two period wrong");
    c_read: cover property (reg_read ##1 reg_rvalid);
    c_boost: cover property (ch3_hstl_boost);
    c_pd: cover property (!ch3_diff_active && !clock_output_ch3_pos_oe);
endmodule
bind ch3drv_output3_ctrl ch3drv_output3_ctrl_sva #(.DIV_W(DIV_W), .PHASE_W(PHASE_W)) u_sva (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .output_sync(output_sync),
    .ch3_divide_value(ch3_divide_value), .ch3_phase_offset(ch3_phase_offset),
    .clock_output_ch3_pos_oe(clock_output_ch3_pos_oe), .ch3_diff_active(ch3_diff_active),
    .ch3_lvds_current(ch3_lvds_current), .ch3_hstl_select(ch3_hstl_select), .ch3_hstl_boost(ch3_hstl_boost),
    .ch3_half_cycle_shift(ch3_half_cycle_shift), .ch3_edge(ch3_edge));

/* File: dv/test_output3_driver_control_regs.sv */
/*
 * random and directed bench for the channel three driver control bank.
 * assumes package, design and checker are compiled ahead of it.
 */
`timescale 1ns/10ps
module test_output3_driver_control_regs;
    logic        clk, reset, wr_s, rd_s, rvalid, sync;            // clock, reset, strobes
    logic [7:0]  addr, wdata, rdata, r;                           // register port
    logic [9:0]  dval;                                            // ratio minus one
    logic [10:0] poff;                                            // half-period offset
    logic        pos, pos_oe, neg, neg_oe, dact, hstl, boost, half, edg;
    logic [2:0]  lvds;                                            // lvds strength
    logic [15:0] lf;                                              // random state
    int          n_errors, checks, i, n, b, k;
    ch3drv_output3_ctrl #(.DIV_W(10), .PHASE_W(11)) uut (
        .clk(clk), .reset(reset), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s),
        .reg_read(rd_s), .reg_rdata(rdata), .reg_rvalid(rvalid), .output_sync(sync),
        .ch3_divide_value(dval), .ch3_phase_offset(poff), .clock_output_ch3_pos(pos),
        .clock_output_ch3_pos_oe(pos_oe), .clock_output_ch3_neg(neg), .clock_output_ch3_neg_oe(neg_oe),
        .ch3_diff_active(dact), .ch3_lvds_current(lvds), .ch3_hstl_select(hstl), .ch3_hstl_boost(boost),
        .ch3_half_cycle_shift(half), .ch3_edge(edg));
    // 25 mhz clock
    always #20 clk = ~clk;
    // next random value
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // leg level for a polarity code and divider level
    function automatic logic pol(input logic [1:0] p, input logic l);
        return (p == 2'h0) ? 1'b1 : (p == 2'h1) ? l : (p == 2'h2) ? ~l : 1'b0;
    endfunction
    // compare and count
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one byte write, gap cycle before next
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(negedge clk);
        wr_s = 1'b0;
    endtask
    // one byte read, answer one cycle on
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd_s = 1'b1;
        @(negedge clk);
        rd_s = 1'b0;
        chk("rvalid", rvalid, 1);
        d = rdata;
    endtask
    // bounded wait for divided clock edge
    task automatic wait_edge(output int c);
        c = 0;
        do
        begin
            @(negedge clk);
            c++;
        end while (edg !== 1'b1 && c < 3000);
        if (c >= 3000)
            chk("edge_wait", 0, 1);
    endtask
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask
    // verdict and stop
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #(40 * 20000);
        n_errors++;
        end_sim;
    end
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        {wr_s, rd_s, sync, addr, wdata} = '0;
        dval = 10'h001;
        poff = 11'h000;
        lf = 16'h5d28;
        n_errors = 0;
        checks = 0;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        rd(8'h2b, r);
        chk("rst_a", r, {2'h0, 2'h1, 3'h2, 1'h0});
        rd(8'h2c, r);
        chk("rst_b", r, 8'h00);
        tend("reset");
        // reserved bits and an unmapped place
        wr(8'h2b, 8'hff);
        rd(8'h2b, r);
        chk("rsv_a", r, 8'hfe);
        wr(8'h2c, 8'hff);
        rd(8'h2c, r);
        chk("rsv_b", r, 8'hfc);
        rd(8'h2d, r);
        chk("unmapped", r, 8'h00);
        // a write to an unmapped place leaves the cmos driver register alone
        wr(8'h2a, 8'h00);
        rd(8'h2c, r);
        chk("unmapped_wr", r, 8'hfc);
        tend("reserved");
        // every drive mode code
        for (i = 0; i < 8; i++)
        begin
            wr(8'h2b, {4'h1, i[2:0], 1'h0});
            chk("lvds", lvds, (i < 4) ? i + 1 : 0);
            chk("hstl", {hstl, boost}, {i[2:1] == 2'h2, i == 5});
            chk("diff", dact, i < 6);
        end
        tend("modes");
        // differential polarity codes at divide by two
        for (i = 0; i < 4; i++)
        begin
            wr(8'h2b, {2'h0, i[1:0], 3'h2, 1'h0});
            wait_edge(n);
            wait_edge(n);
            chk("n1_period", n, 2);
            @(negedge clk);
            chk("diff_hi", {pos_oe, pos, neg_oe, neg}, {1'b1, pol(i[1:0], 1'b1), 1'b1, ~pol(i[1:0], 1'b1)});
            @(negedge clk);
            chk("diff_lo", {pos, neg}, {pol(i[1:0], 1'b0), ~pol(i[1:0], 1'b0)});
        end
        tend("diff_polarity");
        // single-ended legs, random enables
        for (i = 0; i < 8; i++)
        begin
            lf = nxt(lf);
            wr(8'h2b, {4'h0, 2'h3, i[0], 1'h0});
            wr(8'h2c, {lf[7], i[1:0], lf[4], ~i[1:0], 2'h0});
            rd(8'h2c, r);
            chk("cmos_rb", r, {lf[7], i[1:0], lf[4], ~i[1:0], 2'h0});
            wait_edge(n);
            @(negedge clk);
            chk("pos_hi", {pos_oe, pos}, {lf[7], pol(i[1:0], 1'b1)});
            chk("neg_hi", {neg_oe, neg}, {lf[4], pol(~i[1:0], 1'b1)});
            @(negedge clk);
            chk("lo", {pos, neg}, {pol(i[1:0], 1'b0), pol(~i[1:0], 1'b0)});
        end
        tend("cmos");
        // divide ratios, period and high time
        wr(8'h2b, 8'h14);
        for (i = 0; i < 5; i++)
        begin
            lf = nxt(lf);
            dval = (i == 0) ? 10'h002 : (i == 1) ? 10'h3ff : (i == 2) ? 10'h000 : {6'h0, lf[3:0] | 4'h1};
            wait_edge(n);
            wait_edge(n);
            wait_edge(n);
            chk("period", n, dval + 1);
            k = 0;
            repeat (dval + 1)
            begin
                @(negedge clk);
                k += pos;
            end
            chk("high_time", k, (dval + 2) / 2);
        end
        tend("divide");
        // phase offset after power-down release
        for (i = 0; i < 4; i++)
        begin
            lf = nxt(lf);
            poff = (i == 0) ? 11'h000 : (i == 1) ? 11'h007 : (i == 2) ? 11'h7ff : {4'h0, lf[6:0]};
            wr(8'h2b, 8'h94);
            chk("half", half, poff[0]);
            repeat (4) @(negedge clk);
            chk("pd_idle", {pos_oe, neg_oe, dact}, 0);
            k = 0;
            repeat (8)
            begin
                @(negedge clk);
                k += edg;
            end
            chk("pd_edges", k, 0);
            wr(8'h2b, 8'h14);
            wait_edge(n);
            if (i == 0)
                b = n;
            chk("delay", n, b + poff / 2);
        end
        tend("phase");
        // sync taken, then masked
        poff = 11'h000;
        dval = 10'h009;
        for (i = 0; i < 2; i++)
        begin
            wr(8'h2b, {1'h0, i[0], 6'h14});
            wait_edge(n);
            wait_edge(n);
            repeat (2) @(negedge clk);
            sync = 1'b1;
            @(negedge clk);
            sync = 1'b0;
            wait_edge(n);
            chk("sync", n, (i == 1) ? 7 : 1);
        end
        tend("sync");
        end_sim;
    end
endmodule

/* File: rtl/ch3drv_divider.sv */
/*
 * channel three divider with coarse phase delay, sync restart and power-down.
 * assumes one clock; divided clock is produced as a level plus an edge pulse.
 */
`timescale 1ns/10ps
module ch3drv_divider #(
    parameter int DIV_W   = 10,
    parameter int PHASE_W = 11
) (
    input  wire logic               clk,          // input clock
    input  wire logic               reset,        // async, active high
    input  wire logic               powerdown,    // hold divider idle
    input  wire logic               sync_pulse,   // restart, already masked
    input  wire logic [DIV_W-1:0]   divide_value, // ratio minus one
    input  wire logic [PHASE_W-1:0] phase_offset, // half-period units
    output logic                    div_level,    // divided clock level
    output logic                    div_edge      // pulse on rising edge
);

    ch3drv_pkg::ch3drv_div_state_t state_q, state_d;  // divider state
    logic [PHASE_W-1:0] cnt_q, cnt_d;                 // delay or period count
    logic               level_q, level_d;             // registered level
    logic               edge_q, edge_d;               // registered edge pulse
    logic [DIV_W:0]     high_len;                     // cycles high per period

    // high part is ceil of (ratio) over two
    assign high_len  = (DIV_W+1)'((({1'b0, divide_value}) + (DIV_W+1)'(2)) >> 1);
    assign div_level = level_q;
    assign div_edge  = edge_q;

    // next state of the divider
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        level_d = 1'b0;
        edge_d  = 1'b0;
        case (state_q)
            ch3drv_pkg::DIV_OFF:
            begin
                // leave idle once powered up again
                if (!powerdown)
                begin
                    state_d = ch3drv_pkg::DIV_DELAY;
                    cnt_d   = phase_offset >> 1;
                end
            end
            ch3drv_pkg::DIV_DELAY:
            begin
                // wait the coarse part of the phase offset
                if (cnt_q == '0)
                begin
                    state_d = ch3drv_pkg::DIV_RUN;
                    level_d = 1'b1;
                    edge_d  = 1'b1;
                end
                else
                begin
                    cnt_d = cnt_q - PHASE_W'(1);
                end
            end
            ch3drv_pkg::DIV_RUN:
            begin
                // count 0..divide_value, wrapping gives divide_value+1 cycles
                if (cnt_q[DIV_W-1:0] == divide_value)
                begin
                    cnt_d   = '0;
                    level_d = 1'b1;
                    edge_d  = 1'b1;
                end
                else
                begin
                    cnt_d   = cnt_q + PHASE_W'(1);
                    level_d = ({1'b0, cnt_d[DIV_W-1:0]} < high_len);
                end
            end
            default:
            begin
                state_d = ch3drv_pkg::DIV_OFF;
                cnt_d   = '0;
            end
        endcase
        // sync restarts the phase delay from scratch
        if (sync_pulse && !powerdown && state_q != ch3drv_pkg::DIV_OFF)
        begin
            state_d = ch3drv_pkg::DIV_DELAY;
            cnt_d   = phase_offset >> 1;
            level_d = 1'b0;
            edge_d  = 1'b0;
        end
        // power-down wins and holds everything idle
        if (powerdown)
        begin
            state_d = ch3drv_pkg::DIV_OFF;
            cnt_d   = '0;
            level_d = 1'b0;
            edge_d  = 1'b0;
        end
    end

    // register divider state
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= ch3drv_pkg::DIV_OFF;
            cnt_q   <= '0;
            level_q <= 1'b0;
            edge_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            level_q <= level_d;
            edge_q  <= edge_d;
        end
    end

endmodule

/* File: rtl/ch3drv_output3_ctrl.sv */
/*
 * channel three output driver control bank and output path.
 * assumes the serial control port decodes frames and presents byte writes
 * and reads here; divide ratio and phase offset come from registers outside.
 */
`timescale 1ns/10ps
module ch3drv_output3_ctrl #(
    parameter int DIV_W   = ch3drv_pkg::DIV_W,
    parameter int PHASE_W = ch3drv_pkg::PHASE_W
) (
    input  wire logic               clk,                     // input clock, 25 mhz
    input  wire logic               reset,                   // async, active high
    input  wire logic [7:0]         reg_addr,                // control port address
    input  wire logic [7:0]         reg_wdata,               // control port write byte
    input  wire logic               reg_write,               // write strobe
    input  wire logic               reg_read,                // read strobe
    output logic [7:0]              reg_rdata,               // read byte, registered
    output logic                    reg_rvalid,              // read data valid pulse
    input  wire logic               output_sync,             // output sync pulse
    input  wire logic [DIV_W-1:0]   ch3_divide_value,        // ratio minus one
    input  wire logic [PHASE_W-1:0] ch3_phase_offset,        // half-period units
    output logic                    clock_output_ch3_pos,    // positive leg level
    output logic                    clock_output_ch3_pos_oe, // positive leg driven
    output logic                    clock_output_ch3_neg,    // negative leg level
    output logic                    clock_output_ch3_neg_oe, // negative leg driven
    output logic                    ch3_diff_active,         // differential driver on
    output logic [2:0]              ch3_lvds_current,        // lvds strength code
    output logic                    ch3_hstl_select,         // hstl drive selected
    output logic                    ch3_hstl_boost,          // hstl boost selected
    output logic                    ch3_half_cycle_shift,    // fine half-period delay
    output logic                    ch3_edge                 // divided clock edge pulse
);

    logic [7:0]              ctrl_a_q, ctrl_a_d;   // divider/driver register
    logic [7:0]              ctrl_b_q, ctrl_b_d;   // cmos driver register
    logic [7:0]              rdata_q, rdata_d;     // read data
    logic                    rvalid_q, rvalid_d;   // read valid
    ch3drv_pkg::ch3drv_cfg_t cfg;                  // decoded fields
    logic                    div_level;            // divided clock
    logic                    pos_q, pos_d;         // positive leg level
    logic                    neg_q, neg_d;         // negative leg level
    logic                    pos_oe_q, pos_oe_d;   // positive leg enable
    logic                    neg_oe_q, neg_oe_d;   // negative leg enable
    logic                    cmos_mode;            // high-z/cmos mode

    // apply one of the shared polarity encodings to the clock
    function automatic logic apply_pol(input logic [1:0] pol, input logic clk_in);
        case (pol)
            ch3drv_pkg::POL_FORCE_HIGH: apply_pol = 1'b1;
            ch3drv_pkg::POL_NONINV:     apply_pol = clk_in;
            ch3drv_pkg::POL_INV:        apply_pol = ~clk_in;
            ch3drv_pkg::POL_FORCE_LOW:  apply_pol = 1'b0;
            default:                    apply_pol = 1'b1;
        endcase
    endfunction

    // field decode of both registers
    always_comb
    begin
        cfg.ch3_divider_powerdown = ctrl_a_q[ch3drv_pkg::POS_POWERDOWN];
        cfg.ch3_sync_exclude      = ctrl_a_q[ch3drv_pkg::POS_SYNC_EXCLUDE];
        cfg.ch3_diff_polarity     = ctrl_a_q[ch3drv_pkg::POS_DIFF_POL +: 2];
        cfg.ch3_diff_drive_mode   = ctrl_a_q[ch3drv_pkg::POS_DIFF_MODE +: 3];
        cfg.ch3_pos_cmos_enable   = ctrl_b_q[ch3drv_pkg::POS_POS_EN];
        cfg.ch3_pos_cmos_polarity = ctrl_b_q[ch3drv_pkg::POS_POS_POL +: 2];
        cfg.ch3_neg_cmos_enable   = ctrl_b_q[ch3drv_pkg::POS_NEG_EN];
        cfg.ch3_neg_cmos_polarity = ctrl_b_q[ch3drv_pkg::POS_NEG_POL +: 2];
    end

    // register writes and reads
    always_comb
    begin
        ctrl_a_d = ctrl_a_q;
        ctrl_b_d = ctrl_b_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        // writes keep reserved bits at zero
        if (reg_write)
        begin
            if (reg_addr == ch3drv_pkg::ADDR_DIV_DRV_CTRL)
            begin
                ctrl_a_d = reg_wdata & ch3drv_pkg::WMASK_DIV_DRV;
            end
            else if (reg_addr == ch3drv_pkg::ADDR_CMOS_DRV_CTRL)
            begin
                ctrl_b_d = reg_wdata & ch3drv_pkg::WMASK_CMOS_DRV;
            end
        end
        // reads of other addresses return zero
        if (reg_read)
        begin
            rvalid_d = 1'b1;
            if (reg_addr == ch3drv_pkg::ADDR_DIV_DRV_CTRL)
            begin
                rdata_d = ctrl_a_q;
            end
            else if (reg_addr == ch3drv_pkg::ADDR_CMOS_DRV_CTRL)
            begin
                rdata_d = ctrl_b_q;
            end
            else
            begin
                rdata_d = 8'h00;
            end
        end
    end

    // register bank flops
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_a_q <= ch3drv_pkg::RST_DIV_DRV_CTRL;
            ctrl_b_q <= ch3drv_pkg::RST_CMOS_DRV_CTRL;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            ctrl_a_q <= ctrl_a_d;
            ctrl_b_q <= ctrl_b_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // divider; sync reaches it only when not excluded
    ch3drv_divider #(
        .DIV_W   (DIV_W),
        .PHASE_W (PHASE_W)
    ) u_divider (
        .clk          (clk),
        .reset        (reset),
        .powerdown    (cfg.ch3_divider_powerdown),
        .sync_pulse   (output_sync & ~cfg.ch3_sync_exclude),
        .divide_value (ch3_divide_value),
        .phase_offset (ch3_phase_offset),
        .div_level    (div_level),
        .div_edge     (ch3_edge)
    );

    // high-z/cmos for codes 110 and 111
    assign cmos_mode = (cfg.ch3_diff_drive_mode == ch3drv_pkg::MODE_HIZ_CMOS_A) ||
                       (cfg.ch3_diff_drive_mode == ch3drv_pkg::MODE_HIZ_CMOS_B);

    // output driver selection
    always_comb
    begin
        if (cfg.ch3_divider_powerdown)
        begin
            // powered down: legs low and released
            pos_d    = 1'b0;
            neg_d    = 1'b0;
            pos_oe_d = 1'b0;
            neg_oe_d = 1'b0;
        end
        else if (cmos_mode)
        begin
            // two single-ended cmos drivers
            pos_d    = apply_pol(cfg.ch3_pos_cmos_polarity, div_level);
            neg_d    = apply_pol(cfg.ch3_neg_cmos_polarity, div_level);
            pos_oe_d = cfg.ch3_pos_cmos_enable;
            neg_oe_d = cfg.ch3_neg_cmos_enable;
        end
        else
        begin
            // differential driver, complementary legs
            pos_d    = apply_pol(cfg.ch3_diff_polarity, div_level);
            neg_d    = ~pos_d;
            pos_oe_d = 1'b1;
            neg_oe_d = 1'b1;
        end
    end

    // output leg flops
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pos_q    <= 1'b0;
            neg_q    <= 1'b0;
            pos_oe_q <= 1'b0;
            neg_oe_q <= 1'b0;
        end
        else
        begin
            pos_q    <= pos_d;
            neg_q    <= neg_d;
            pos_oe_q <= pos_oe_d;
            neg_oe_q <= neg_oe_d;
        end
    end

    // driver strength selection, straight from the mode field
    always_comb
    begin
        ch3_diff_active  = ~cmos_mode & ~cfg.ch3_divider_powerdown;
        ch3_lvds_current = 3'h0;
        ch3_hstl_select  = 1'b0;
        ch3_hstl_boost   = 1'b0;
        case (cfg.ch3_diff_drive_mode)
            ch3drv_pkg::MODE_LVDS_HALF:  ch3_lvds_current = 3'h1;
            ch3drv_pkg::MODE_LVDS_3Q:    ch3_lvds_current = 3'h2;
            ch3drv_pkg::MODE_LVDS_FULL:  ch3_lvds_current = 3'h3;
            ch3drv_pkg::MODE_LVDS_125:   ch3_lvds_current = 3'h4;
            ch3drv_pkg::MODE_HSTL:       ch3_hstl_select  = 1'b1;
            ch3drv_pkg::MODE_HSTL_BOOST:
            begin
                ch3_hstl_select = 1'b1;
                ch3_hstl_boost  = 1'b1;
            end
            default:                     ch3_lvds_current = 3'h0;
        endcase
    end

    // odd offsets ask the analog stage for a half-period shift
    assign ch3_half_cycle_shift    = ch3_phase_offset[0];
    assign reg_rdata               = rdata_q;
    assign reg_rvalid              = rvalid_q;
    assign clock_output_ch3_pos    = pos_q;
    assign clock_output_ch3_neg    = neg_q;
    assign clock_output_ch3_pos_oe = pos_oe_q;
    assign clock_output_ch3_neg_oe = neg_oe_q;

endmodule

/* File: rtl/ch3drv_pkg.sv */
/*
 * constants, field layout and configuration carrier for the channel three
 * output driver control bank.
 * assumes the serial control port hands in whole byte writes at an address.
 */
package ch3drv_pkg;

    // register addresses on the control port
    localparam logic [7:0] ADDR_DIV_DRV_CTRL  = 8'h2b;  // channel3_divider_driver_ctrl
    localparam logic [7:0] ADDR_CMOS_DRV_CTRL = 8'h2c;  // channel3_cmos_driver_ctrl

    // reset values: polarity non-inverted, lvds full current
    localparam logic [7:0] RST_DIV_DRV_CTRL   = 8'h14;
    localparam logic [7:0] RST_CMOS_DRV_CTRL  = 8'h00;

    // writable bits; reserved bits stay zero
    localparam logic [7:0] WMASK_DIV_DRV      = 8'hfe;
    localparam logic [7:0] WMASK_CMOS_DRV     = 8'hfc;

    // field positions, first register
    localparam int POS_POWERDOWN    = 7;
    localparam int POS_SYNC_EXCLUDE = 6;
    localparam int POS_DIFF_POL     = 4;
    localparam int POS_DIFF_MODE    = 1;
    // field positions, second register
    localparam int POS_POS_EN       = 7;
    localparam int POS_POS_POL      = 5;
    localparam int POS_NEG_EN       = 4;
    localparam int POS_NEG_POL      = 2;

    // field widths
    localparam int DIV_W   = 10;
    localparam int PHASE_W = 11;

    // polarity encodings shared by all three drivers
    localparam logic [1:0] POL_FORCE_HIGH = 2'h0;
    localparam logic [1:0] POL_NONINV     = 2'h1;
    localparam logic [1:0] POL_INV        = 2'h2;
    localparam logic [1:0] POL_FORCE_LOW  = 2'h3;

    // differential driver mode encodings
    localparam logic [2:0] MODE_LVDS_HALF  = 3'h0;
    localparam logic [2:0] MODE_LVDS_3Q    = 3'h1;
    localparam logic [2:0] MODE_LVDS_FULL  = 3'h2;
    localparam logic [2:0] MODE_LVDS_125   = 3'h3;
    localparam logic [2:0] MODE_HSTL       = 3'h4;
    localparam logic [2:0] MODE_HSTL_BOOST = 3'h5;
    localparam logic [2:0] MODE_HIZ_CMOS_A = 3'h6;
    localparam logic [2:0] MODE_HIZ_CMOS_B = 3'h7;

    // decoded configuration of the channel
    typedef struct packed {
        logic       ch3_divider_powerdown;
        logic       ch3_sync_exclude;
        logic [1:0] ch3_diff_polarity;
        logic [2:0] ch3_diff_drive_mode;
        logic       ch3_pos_cmos_enable;
        logic [1:0] ch3_pos_cmos_polarity;
        logic       ch3_neg_cmos_enable;
        logic [1:0] ch3_neg_cmos_polarity;
    } ch3drv_cfg_t;

    // divider state machine
    typedef enum logic [1:0] {
        DIV_OFF   = 2'b00,
        DIV_DELAY = 2'b01,
        DIV_RUN   = 2'b10
    } ch3drv_div_state_t;

endpackage
